//--- dv/issue_model.sv
// Issue-side model that presents operations to the unit
module issue_model
  (
    // Clock
    input  wire logic          clk_sys_i,
    // Issue outputs
    output logic               issue_valid_o,
    output zidep_pkg::issue_t  issue_o
  );
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    issue_valid_o = 1'b0;
    issue_o       = '0;
  end

  // Called at a falling edge; idle cycles carry scrambled operands
  task automatic send(input logic v, input zidep_pkg::issue_t x);
    issue_valid_o = v;
    if (v)
      issue_o = x;
    else
      issue_o = zidep_pkg::issue_t'(~issue_o);
  endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for the zero-index and deposit unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk_sys_i;
  logic               reset_i;
  logic               clk_en_i;
  logic               issue_valid_i;
  zidep_pkg::issue_t  issue_i;
  zidep_pkg::result_t result_o;
  zidep_pkg::result_t held;
  int                 miscompares = 0;
  int                 n_checks = 0;

  issue_model issue_u (.clk_sys_i(clk_sys_i), .issue_valid_o(issue_valid_i), .issue_o(issue_i));
  zero_index_and_bitfield_deposit dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .clk_en_i(clk_en_i), .issue_valid_i(issue_valid_i), .issue_i(issue_i), .result_o(result_o));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  // --------------------------------------------------
  // Reference model and helpers
  // --------------------------------------------------
  function automatic zidep_pkg::result_t model(zidep_pkg::issue_t x);
    zidep_pkg::result_t r;
    logic [63:0] s;
    logic [64:0] m;
    int n, p, len;
    logic mg, rg;
    r = '0;
    r.wr_en = 1'b1;
    if (x.op < zidep_pkg::OP_DEP_MERGE_REG)
    begin
      n = (x.op < zidep_pkg::OP_SCAN_HALF_LEFT) ? 8 : 4;
      r.general_register = 64'(n);
      r.tag = x.src_a_tag;
      // Lowest scan index found last wins
      for (int i = n - 1; i >= 0; i--)
      begin
        p = x.op[0] ? i : n - 1 - i;
        if (((x.src_a >> (p * 64 / n)) & ((64'h1 << (64 / n)) - 64'h1)) == 64'h0)
          r.general_register = 64'(i);
      end
      return r;
    end
    mg = x.op < zidep_pkg::OP_DEP_ZERO_REG;
    rg = x.op inside {zidep_pkg::OP_DEP_MERGE_REG, zidep_pkg::OP_DEP_ZERO_REG};
    s = rg ? x.src_a : mg ? {64{x.imm[0]}} : {{56{x.imm[7]}}, x.imm};
    len = (x.op == zidep_pkg::OP_DEP_MERGE_REG ? int'(x.len_enc[3:0]) : int'(x.len_enc)) + 1;
    if (x.pos + len > 64)
      len = 64 - x.pos;
    m = ((65'h1 << len) - 65'h1) << x.pos;
    r.general_register = ((mg ? x.src_b : 64'h0) & ~m[63:0]) | ((s << x.pos) & m[63:0]);
    r.tag = (mg & x.src_b_tag) | (rg & x.src_a_tag);
    return r;
  endfunction

  function automatic zidep_pkg::issue_t mk(zidep_pkg::op_t op, logic [63:0] a, logic [7:0] imm,
                                           logic [5:0] pos, logic [5:0] le, logic [1:0] tg);
    mk = '{op, 1'b1, a, tg[0], 64'h0123_4567_89ab_cdef, tg[1], imm, pos, le};
  endfunction

  task automatic chk(zidep_pkg::result_t seen, zidep_pkg::result_t exp);
    n_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered at a falling edge; result is judged one cycle later
  task automatic run(logic v, zidep_pkg::issue_t x);
    zidep_pkg::result_t e;
    issue_u.send(v, x);
    if (v && x.guard_predicate)
      held = model(x);
    e = held;
    e.wr_en = v && x.guard_predicate;
    @(negedge clk_sys_i);
    chk(result_o, e);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------
  // Scenarios
  // --------------------------------------------------
  task automatic t_scan();
    logic [63:0] src [4] = '{64'h0102_0304_0506_0708, 64'h0100_0000_0203_0400,
                             64'h0000_1200_3400_0056, 64'h0};
    for (int o = 0; o < 4; o++)
      for (int k = 0; k < 4; k++)
        run(1'b1, mk(zidep_pkg::op_t'(o), src[k], 8'h00, 6'h00, 6'h00, 2'(k)));
    $display("test scan done");
  endtask

  task automatic t_dep();
    logic [11:0] geo [5] = '{{6'h24, 6'h0f}, {6'h00, 6'h3f}, {6'h3c, 6'h07}, {6'h3f, 6'h00},
                             {6'h08, 6'h3f}};
    for (int o = 4; o < 8; o++)
      for (int g = 0; g < 5; g++)
        for (int b = 0; b < 2; b++)
          run(1'b1, mk(zidep_pkg::op_t'(o), 64'hdead_beef_cafe_1234, b ? 8'ha5 : 8'h5a,
                       geo[g][11:6], geo[g][5:0], 2'(g + b)));
    $display("test deposit done");
  endtask

  task automatic t_hold();
    zidep_pkg::issue_t x;
    x = mk(zidep_pkg::OP_DEP_ZERO_IMM, 64'h0, 8'h81, 6'h04, 6'h07, 2'h3);
    run(1'b1, x);
    x.guard_predicate = 1'b0;
    x.op = zidep_pkg::OP_SCAN_BYTE_RIGHT;
    run(1'b1, x);
    run(1'b0, x);
    x.guard_predicate = 1'b1;
    x.src_a_tag = 1'b0;
    run(1'b1, x);
    // Enable low must freeze the whole result
    clk_en_i = 1'b0;
    issue_u.send(1'b1, mk(zidep_pkg::OP_SCAN_HALF_LEFT, 64'h0, 8'h00, 6'h00, 6'h00, 2'h3));
    @(negedge clk_sys_i);
    chk(result_o, held);
    clk_en_i = 1'b1;
    reset_i = 1'b1;
    @(negedge clk_sys_i);
    chk(result_o, '0);
    reset_i = 1'b0;
    held = '0;
    run(1'b0, x);
    $display("test hold done");
  endtask

  // --------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------
  initial
  begin
    reset_i = 1'b1;
    clk_en_i = 1'b1;
    held = '0;
    repeat (20) @(negedge clk_sys_i);
    reset_i = 1'b0;
    t_scan();
    t_dep();
    t_hold();
    give_verdict();
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys_i);
    miscompares++;
    give_verdict();
  end
endmodule

//--- hdl/zero_index_and_bitfield_deposit.sv
// Zero-index scan and bit-field deposit execution unit with one registered result stage
// Behaviour
// [RQ1] Scan the 64-bit source as aligned bytes or halfwords looking for zero.
// [RQ2] Left scan goes from most significant element down; right scan goes up.
// [RQ3] Result is index of first zero element in scan order, from 0.
// [RQ4] No zero element gives 8 for bytes and 4 for halfwords.
// [RQ5] Merging deposit overwrites a field of the second operand with source low bits.
// [RQ6] Merge source is first register operand or sign-extended one-bit immediate.
// [RQ7] Merge field length 1 to 16 with register source, 1 to 64 with immediate.
// [RQ8] Field lowest bit sits at position 0 to 63 and extends upward.
// [RQ9] Zeroing deposit inserts register or sign-extended 8-bit immediate, clears rest.
// [RQ10] Field bits beyond destination bit 63 are dropped.
// [RQ11] Length immediate decodes as encoded value plus one.
// [RQ12] Deposit tag ORs second-operand tag (merge) and source tag (register forms).
// [RQ13] Scan result tag copies the source operand tag.
// [RQ14] Destination and tag are written only when the guard predicate is true.
module zero_index_and_bitfield_deposit
  #(
    // Word width; only the 64-bit issue word is served
    parameter int unsigned DATA_W = 64
  )
  (
    // Clock, reset and enable
    input  wire logic               clk_sys_i,
    input  wire logic               reset_i,
    input  wire logic               clk_en_i,
    // Issue side
    input  wire logic               issue_valid_i,
    input  wire zidep_pkg::issue_t  issue_i,
    // Register file side
    output zidep_pkg::result_t      result_o
  );

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (DATA_W != zidep_pkg::WORD_W)
  begin : g_width_check
    $error("DATA_W must equal the issue word width");
  end

  // ----------------------------------------------------------------
  // Scan
  // ----------------------------------------------------------------
  logic [7:0] byte_zero;
  logic [3:0] half_zero;
  logic [3:0] scan_index;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      byte_zero[i] = (issue_i.src_a[i*8 +: 8] == 8'h00); // RQ1
    end
    for (int i = 0; i < 4; i++)
    begin
      half_zero[i] = (issue_i.src_a[i*16 +: 16] == 16'h0000); // RQ1
    end
    scan_index = 4'h0;
    case (issue_i.op)
      zidep_pkg::OP_SCAN_BYTE_LEFT:
      begin
        scan_index = zidep_pkg::BYTE_DEFAULT; // RQ4
        for (int i = 0; i < 8; i++)
        begin
          if (byte_zero[i])
          begin
            scan_index = 4'(7 - i); // RQ2 RQ3
          end
        end
      end
      zidep_pkg::OP_SCAN_BYTE_RIGHT:
      begin
        scan_index = zidep_pkg::BYTE_DEFAULT; // RQ4
        for (int i = 7; i >= 0; i--)
        begin
          if (byte_zero[i])
          begin
            scan_index = 4'(i); // RQ2 RQ3
          end
        end
      end
      zidep_pkg::OP_SCAN_HALF_LEFT:
      begin
        scan_index = zidep_pkg::HALF_DEFAULT; // RQ4
        for (int i = 0; i < 4; i++)
        begin
          if (half_zero[i])
          begin
            scan_index = 4'(3 - i); // RQ2 RQ3
          end
        end
      end
      default:
      begin
        scan_index = zidep_pkg::HALF_DEFAULT; // RQ4
        for (int i = 3; i >= 0; i--)
        begin
          if (half_zero[i])
          begin
            scan_index = 4'(i); // RQ2 RQ3
          end
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Deposit
  // ----------------------------------------------------------------
  logic [6:0]        dep_len;
  logic [DATA_W-1:0] dep_src;
  logic [DATA_W-1:0] dep_base;
  logic [DATA_W-1:0] field_mask;
  logic [DATA_W-1:0] low_mask;
  logic [DATA_W-1:0] dep_word;
  logic              dep_tag;
  logic              is_merge;
  logic              is_reg;

  always_comb
  begin
    is_merge = (issue_i.op == zidep_pkg::OP_DEP_MERGE_REG) ||
               (issue_i.op == zidep_pkg::OP_DEP_MERGE_IMM);
    is_reg   = (issue_i.op == zidep_pkg::OP_DEP_MERGE_REG) ||
               (issue_i.op == zidep_pkg::OP_DEP_ZERO_REG);
    dep_len  = {1'b0, issue_i.len_enc} + 7'h01; // RQ11
    if (issue_i.op == zidep_pkg::OP_DEP_MERGE_REG)
    begin
      // Register merge carries a 4-bit length field
      dep_len = {3'b000, issue_i.len_enc[3:0]} + 7'h01; // RQ7 RQ11
    end
    if (is_reg)
    begin
      dep_src = issue_i.src_a; // RQ6 RQ9
    end
    else if (is_merge)
    begin
      dep_src = {64{issue_i.imm[0]}}; // RQ6
    end
    else
    begin
      dep_src = {{56{issue_i.imm[7]}}, issue_i.imm}; // RQ9
    end
    dep_base = is_merge ? issue_i.src_b : 64'h0000_0000_0000_0000; // RQ5 RQ9
    // Shifting out past bit 63 truncates an overlong field
    low_mask   = (dep_len == zidep_pkg::WORD_BITS) ? {64{1'b1}} :
                 ((64'h0000_0000_0000_0001 << dep_len) - 64'h0000_0000_0000_0001);
    field_mask = low_mask << issue_i.pos; // RQ8 RQ10
    dep_word   = (dep_base & ~field_mask) |
                 ((dep_src << issue_i.pos) & field_mask); // RQ5 RQ8 RQ10
    dep_tag    = (is_merge & issue_i.src_b_tag) | (is_reg & issue_i.src_a_tag); // RQ12
  end

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  zidep_pkg::state_t st_r;
  zidep_pkg::state_t st_nxt;
  logic              is_scan;

  always_comb
  begin
    is_scan = !issue_i.op[2];
    st_nxt  = st_r;
    st_nxt.res.wr_en = issue_valid_i & issue_i.guard_predicate; // RQ14
    if (issue_valid_i && issue_i.guard_predicate)
    begin
      if (is_scan)
      begin
        st_nxt.res.general_register = {60'h0, scan_index};
        st_nxt.res.tag              = issue_i.src_a_tag; // RQ13
      end
      else
      begin
        st_nxt.res.general_register = dep_word;
        st_nxt.res.tag              = dep_tag; // RQ12
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_r <= '0;
    end
    else if (clk_en_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign result_o = st_r.res;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_guard_blocks_write: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ14
    clk_en_i && !(issue_valid_i && issue_i.guard_predicate) |=> !result_o.wr_en)
    else $error("write without true guard");

  chk_guard_then_write: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ14
    clk_en_i && issue_valid_i && issue_i.guard_predicate |=> result_o.wr_en)
    else $error("guarded op did not write");

  chk_scan_byte_default: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ4
    clk_en_i && issue_valid_i && issue_i.guard_predicate && byte_zero == 8'h00 &&
    issue_i.op == zidep_pkg::OP_SCAN_BYTE_LEFT
    |=> result_o.general_register == 64'h0000_0000_0000_0008)
    else $error("byte scan default wrong");

  chk_scan_half_default: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ4
    clk_en_i && issue_valid_i && issue_i.guard_predicate && half_zero == 4'h0 &&
    issue_i.op == zidep_pkg::OP_SCAN_HALF_RIGHT
    |=> result_o.general_register == 64'h0000_0000_0000_0004)
    else $error("halfword scan default wrong");

  chk_scan_left_top: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ2
    clk_en_i && issue_valid_i && issue_i.guard_predicate && byte_zero[7] &&
    issue_i.op == zidep_pkg::OP_SCAN_BYTE_LEFT
    |=> result_o.general_register == 64'h0000_0000_0000_0000)
    else $error("left byte scan missed top byte");

  chk_scan_right_low: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ3
    clk_en_i && issue_valid_i && issue_i.guard_predicate && half_zero[0] &&
    issue_i.op == zidep_pkg::OP_SCAN_HALF_RIGHT
    |=> result_o.general_register == 64'h0000_0000_0000_0000)
    else $error("right halfword scan missed low element");

  chk_scan_tag_copy: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ13
    clk_en_i && issue_valid_i && issue_i.guard_predicate && is_scan
    |=> result_o.tag == $past(issue_i.src_a_tag))
    else $error("scan tag not copied");

  chk_zero_imm_tag: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ12
    clk_en_i && issue_valid_i && issue_i.guard_predicate &&
    issue_i.op == zidep_pkg::OP_DEP_ZERO_IMM |=> !result_o.tag)
    else $error("zeroing immediate deposit kept a tag");

  chk_zero_outside: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ9
    clk_en_i && issue_valid_i && issue_i.guard_predicate && !is_merge && !is_scan
    |=> (result_o.general_register & ~$past(field_mask)) == 64'h0000_0000_0000_0000)
    else $error("zeroing deposit left bits outside field");

  chk_merge_keeps: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ5
    clk_en_i && issue_valid_i && issue_i.guard_predicate && is_merge
    |=> (result_o.general_register & ~$past(field_mask)) ==
        ($past(issue_i.src_b) & ~$past(field_mask)))
    else $error("merge deposit changed bits outside field");

  chk_len_decode: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ11
    issue_i.op == zidep_pkg::OP_DEP_ZERO_REG &&
    ({1'b0, issue_i.pos} + {1'b0, issue_i.len_enc}) < 7'h3F
    |-> field_mask[issue_i.pos + issue_i.len_enc] &&
        !field_mask[issue_i.pos + issue_i.len_enc + 6'h01])
    else $error("length decode wrong");

  chk_field_lsb: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ8
    !is_scan |-> field_mask[issue_i.pos])
    else $error("field does not start at position");

  chk_scan_upper_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ3
    clk_en_i && issue_valid_i && issue_i.guard_predicate && is_scan
    |=> result_o.general_register[63:4] == 60'h0)
    else $error("scan index has upper bits set");

  chk_scan_byte_right: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ4
    clk_en_i && issue_valid_i && issue_i.guard_predicate && byte_zero == 8'h00 &&
    issue_i.op == zidep_pkg::OP_SCAN_BYTE_RIGHT
    |=> result_o.general_register == 64'h0000_0000_0000_0008)
    else $error("right byte scan default wrong");

  chk_scan_half_top: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ2
    clk_en_i && issue_valid_i && issue_i.guard_predicate && half_zero[3] &&
    issue_i.op == zidep_pkg::OP_SCAN_HALF_LEFT
    |=> result_o.general_register == 64'h0000_0000_0000_0000)
    else $error("left halfword scan missed top element");

  chk_merge_imm_fill: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ6
    clk_en_i && issue_valid_i && issue_i.guard_predicate &&
    issue_i.op == zidep_pkg::OP_DEP_MERGE_IMM
    |=> (result_o.general_register & $past(field_mask)) ==
        ($past(issue_i.imm[0]) ? $past(field_mask) : 64'h0000_0000_0000_0000))
    else $error("merge immediate field not all ones or all zeros");

  chk_merge_reg_len: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ7
    issue_i.op == zidep_pkg::OP_DEP_MERGE_REG && issue_i.pos < 6'h30
    |-> !field_mask[issue_i.pos + 6'h10])
    else $error("register merge field longer than 16 bits");

  chk_zero_reg_field: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ9
    clk_en_i && issue_valid_i && issue_i.guard_predicate &&
    issue_i.op == zidep_pkg::OP_DEP_ZERO_REG
    |=> (result_o.general_register & $past(field_mask)) ==
        (($past(issue_i.src_a) << $past(issue_i.pos)) & $past(field_mask)))
    else $error("zeroing register deposit field wrong");

  chk_zero_imm_sign: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ9
    clk_en_i && issue_valid_i && issue_i.guard_predicate &&
    issue_i.op == zidep_pkg::OP_DEP_ZERO_IMM
    |=> (result_o.general_register & $past(field_mask)) ==
        (({{56{$past(issue_i.imm[7])}}, $past(issue_i.imm)} << $past(issue_i.pos)) &
         $past(field_mask)))
    else $error("zeroing immediate deposit field wrong");

  chk_no_wrap: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ10
    !is_scan |-> (field_mask & ((64'h0000_0000_0000_0001 << issue_i.pos) -
                  64'h0000_0000_0000_0001)) == 64'h0000_0000_0000_0000)
    else $error("deposited field wrapped below position");

  chk_merge_reg_tag: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ12
    clk_en_i && issue_valid_i && issue_i.guard_predicate &&
    issue_i.op == zidep_pkg::OP_DEP_MERGE_REG
    |=> result_o.tag == ($past(issue_i.src_a_tag) | $past(issue_i.src_b_tag)))
    else $error("register merge tag not the OR of both tags");

  chk_zero_reg_tag: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ12
    clk_en_i && issue_valid_i && issue_i.guard_predicate &&
    issue_i.op == zidep_pkg::OP_DEP_ZERO_REG
    |=> result_o.tag == $past(issue_i.src_a_tag))
    else $error("zeroing register tag not the source tag");

  chk_guard_holds_data: assert property (@(posedge clk_sys_i) disable iff (reset_i) // RQ14
    clk_en_i && !(issue_valid_i && issue_i.guard_predicate)
    |=> $stable(result_o.general_register) && $stable(result_o.tag))
    else $error("refused op changed the result");

endmodule

//--- hdl/zidep_pkg.sv
// Package: operation codes, widths and scan defaults for the zero-index and deposit unit
package zidep_pkg;

  localparam int unsigned WORD_W        = 64;
  localparam int unsigned POS_W         = 6;
  localparam int unsigned LEN_W         = 6;
  localparam logic [6:0]  WORD_BITS     = 7'h40;
  localparam logic [3:0]  BYTE_DEFAULT  = 4'h8;
  localparam logic [3:0]  HALF_DEFAULT  = 4'h4;
  localparam logic [3:0]  MERGE_REG_MAX = 4'hF;

  typedef enum logic [2:0] {
    OP_SCAN_BYTE_LEFT,
    OP_SCAN_BYTE_RIGHT,
    OP_SCAN_HALF_LEFT,
    OP_SCAN_HALF_RIGHT,
    OP_DEP_MERGE_REG,
    OP_DEP_MERGE_IMM,
    OP_DEP_ZERO_REG,
    OP_DEP_ZERO_IMM
  } op_t;

  typedef struct packed {
    op_t               op;
    logic              guard_predicate;
    logic [63:0]       src_a;
    logic              src_a_tag;
    logic [63:0]       src_b;
    logic              src_b_tag;
    logic [7:0]        imm;
    logic [5:0]        pos;
    logic [5:0]        len_enc;
  } issue_t;

  typedef struct packed {
    logic              wr_en;
    logic [63:0]       general_register;
    logic              tag;
  } result_t;

  typedef struct packed {
    result_t           res;
  } state_t;

endpackage
